// ### hdl/spfa_defs.vh
// spfa_defs.vh: register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the serial port alignment design files
`ifndef SPFA_DEFS_VH
`define SPFA_DEFS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SPFA_OFS_RXCFG 12'h000
`define SPFA_OFS_TXCFG 12'h040
`define SPFA_OFS_RXSTAT 12'h080
`define SPFA_OFS_TXSTAT 12'h0c0

// ----------------------------------------
// configuration fields
// ----------------------------------------
`define SPFA_CFG_CLK_INV 0
`define SPFA_CFG_SYNC_INV 1
`define SPFA_CFG_EARLY_LSB 2
`define SPFA_CFG_MODE_LSB 4
`define SPFA_CFG_FORCE_HIGH 6
`define SPFA_CFG_RESET 7'h00

// ----------------------------------------
// early modes and frame modes
// ----------------------------------------
`define SPFA_EARLY_0 2'h0
`define SPFA_EARLY_HALF 2'h1
`define SPFA_EARLY_1 2'h2
`define SPFA_EARLY_2 2'h3
`define SPFA_MODE_T1 2'h0
`define SPFA_MODE_E1 2'h1
`define SPFA_MODE_4M 2'h2
`define SPFA_MODE_8M 2'h3

// ----------------------------------------
// frame lengths in line clocks
// ----------------------------------------
`define SPFA_LEN_T1 10'd193
`define SPFA_LEN_E1 10'd256
`define SPFA_LEN_4M 10'd512
`define SPFA_LEN_8M 11'd1024
`define SPFA_BYTE_BITS 3

`endif

// ### hdl/spfa_dir.v
// spfa_dir.v: one direction of one port: line clock edge finder, sync catch, bit counter
// assumes line pins are asynchronous to clk and pass two flip-flops here
`include "spfa_defs.vh"
`default_nettype none

module spfa_dir (
  input wire clk,
  input wire rst_n,
  input wire line_clock,
  input wire line_sync,
  input wire line_data,
  input wire clk_inv,
  input wire sync_inv,
  input wire [1:0] early_mode,
  input wire [1:0] frame_mode,
  output reg data_edge,
  output reg sync_seen,
  output reg [9:0] bit_count_q,
  output reg byte_edge,
  output reg frame_edge,
  output reg data_q
);
  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  reg [1:0] clk_s_q;
  reg [1:0] sync_s_q;
  reg [1:0] data_s_q;
  reg clk_prev_q;
  reg sync_hold_q;
  reg armed_q;
  reg [1:0] pend_q;
  wire rise;
  wire fall;
  wire sync_act;
  wire sync_edge;
  wire [10:0] frame_len;
  wire [10:0] count_inc;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_s_q <= 2'h0;
      sync_s_q <= 2'h0;
      data_s_q <= 2'h0;
      clk_prev_q <= 1'b0;
    end else begin
      clk_s_q <= {clk_s_q[0], line_clock};
      sync_s_q <= {sync_s_q[0], line_sync};
      data_s_q <= {data_s_q[0], line_data};
      clk_prev_q <= clk_s_q[1];
    end
  end

  assign rise = clk_s_q[1] & ~clk_prev_q;
  assign fall = ~clk_s_q[1] & clk_prev_q;
  // sync polarity per direction
  assign sync_act = sync_s_q[1] ^ sync_inv; // R5
  // half early samples on the data edge, the rest on the opposite edge
  assign sync_edge = ((early_mode == `SPFA_EARLY_HALF) ^ clk_inv) ? rise : fall; // R7 R15
  assign frame_len = (frame_mode == `SPFA_MODE_T1) ? {1'b0, `SPFA_LEN_T1} :
                     (frame_mode == `SPFA_MODE_E1) ? {1'b0, `SPFA_LEN_E1} :
                     (frame_mode == `SPFA_MODE_4M) ? {1'b0, `SPFA_LEN_4M} : `SPFA_LEN_8M; // R8
  // one bit wider than the counter so the 1024 length can be matched
  assign count_inc = {1'b0, bit_count_q} + 11'd1;

  // ----------------------------------------
  // counter, sync alignment
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_edge <= 1'b0;
      sync_seen <= 1'b0;
      bit_count_q <= 10'h000;
      byte_edge <= 1'b0;
      frame_edge <= 1'b0;
      data_q <= 1'b0;
      sync_hold_q <= 1'b0;
      armed_q <= 1'b0;
      pend_q <= 2'h0;
    end else begin
      data_edge <= clk_inv ? fall : rise; // R1 R11
      sync_seen <= 1'b0;
      byte_edge <= 1'b0;
      frame_edge <= 1'b0;
      // one line clock wide pulse: catch on its sampling edge only
      if (sync_edge) begin
        sync_hold_q <= sync_act & ~armed_q; // R4
        armed_q <= sync_act;
      end else begin
        sync_hold_q <= 1'b0;
      end
      if (clk_inv ? fall : rise) begin
        data_q <= data_s_q[1]; // R3
        // early sync delays the frame origin by its lead in data edges
        if (pend_q == 2'h1) begin
          bit_count_q <= 10'h000; // R4 R8
          frame_edge <= 1'b1;
          byte_edge <= 1'b1;
          pend_q <= 2'h0;
        end else begin
          if (pend_q != 2'h0)
            pend_q <= pend_q - 2'h1;
          // free running after one sync
          if (count_inc == frame_len) begin
            bit_count_q <= 10'h000; // R9
            frame_edge <= 1'b1;
            byte_edge <= 1'b1;
          end else begin
            bit_count_q <= count_inc[9:0];
            byte_edge <= (count_inc[`SPFA_BYTE_BITS-1:0] == 3'h0); // R16
          end
        end
      end
      if (sync_hold_q) begin
        sync_seen <= 1'b1;
        // zero and half early land on the current frame start
        case (early_mode)
          `SPFA_EARLY_1: pend_q <= 2'h2; // R6
          `SPFA_EARLY_2: pend_q <= 2'h3;
          default: pend_q <= 2'h1;
        endcase
      end
    end
  end
endmodule

`default_nettype wire

// ### hdl/spfa_top.v
// spfa_top.v: sixteen port serial front end with APB configuration and status
// assumes line pins are asynchronous to clk; apb runs on clk
//
// Summary of operation
// R1: receive data is taken on rising line clock edges, or falling ones when inverted, per port.
// R2: receive clocks of ports 0-2 run up to 52MHz and of ports 3-15 up to 10MHz.
// R3: receive data is sampled on the rising edge normally and the falling edge when inverted.
// R4: a one line clock wide sync pulse forces byte and frame alignment for its direction.
// R5: sync is active high normally and active low in inverted sync mode, per direction.
// R6: sync may be on time or one half, one or two line clocks early as configured.
// R7: receive sync is sampled on the falling edge except in half early mode; inversion swaps.
// R8: a valid sync resets a bit counter that rolls over at 193, 256, 512 or 1024 clocks.
// R9: after one sync, boundaries are kept by counting line clocks alone.
// R10: a port needing no alignment has its sync input held low by the system.
// R11: transmit data changes on rising line clock edges, or falling ones when inverted.
// R12: transmit clocks of ports 0-1 run up to 52MHz and of ports 2-15 up to 10MHz.
// R13: the transmit data output can be forced to a constant high level.
// R14: the system ties unused clock and receive data inputs low.
// R15: transmit sync edge choice follows the same table as receive sync.
// R16: byte edges fall every eight line clocks from the counter origin; modes are per direction.
`include "spfa_defs.vh"
`default_nettype none

module spfa_top #(
  parameter NPORT = 16
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [NPORT-1:0] rx_line_clock,
  input wire [NPORT-1:0] rx_line_data,
  input wire [NPORT-1:0] rx_frame_sync,
  input wire [NPORT-1:0] tx_line_clock,
  input wire [NPORT-1:0] tx_frame_sync,
  input wire [NPORT-1:0] tx_bit_in,
  output wire [NPORT-1:0] tx_line_data,
  output wire [NPORT-1:0] rx_bit_out,
  output wire [NPORT-1:0] rx_bit_valid,
  output wire [NPORT-1:0] rx_byte_start,
  output wire [NPORT-1:0] rx_frame_start,
  output wire [NPORT-1:0] tx_bit_take,
  output wire [NPORT-1:0] tx_byte_start,
  output wire [NPORT-1:0] tx_frame_start
);
  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  // clock rate limits hold only while clk samples well above the line rate;
  // at 50 MHz lines up to about 10 MHz are tracked
  reg [6:0] rx_cfg_q [0:NPORT-1]; // R2
  reg [6:0] tx_cfg_q [0:NPORT-1]; // R12
  reg [NPORT-1:0] rx_aligned_q;
  reg [NPORT-1:0] tx_aligned_q;
  wire [NPORT-1:0] rx_seen;
  wire [NPORT-1:0] tx_seen;
  wire [9:0] rx_cnt [0:NPORT-1];
  wire [9:0] tx_cnt [0:NPORT-1];
  wire wr_en;
  wire [3:0] idx;
  wire [1:0] bank;
  wire mapped;

  assign pready = 1'b1;
  assign idx = paddr[5:2];
  assign bank = paddr[7:6];
  assign mapped = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0) && (idx < NPORT);
  assign pslverr = psel & penable & ~mapped;
  assign wr_en = psel & penable & pwrite & mapped;

  always @* begin
    prdata = 32'h0000_0000;
    if (mapped) begin
      case (bank)
        2'h0: prdata = {25'h0, rx_cfg_q[idx]};
        2'h1: prdata = {25'h0, tx_cfg_q[idx]};
        2'h2: prdata = {21'h0, rx_aligned_q[idx], rx_cnt[idx]};
        default: prdata = {21'h0, tx_aligned_q[idx], tx_cnt[idx]};
      endcase
    end
  end

  // ----------------------------------------
  // per port datapath
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : port
      wire tx_edge;
      reg tx_out_q;

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rx_cfg_q[g] <= `SPFA_CFG_RESET;
          tx_cfg_q[g] <= `SPFA_CFG_RESET;
          rx_aligned_q[g] <= 1'b0;
          tx_aligned_q[g] <= 1'b0;
          tx_out_q <= 1'b0;
        end else begin
          if (wr_en && idx == g && bank == 2'h0)
            rx_cfg_q[g] <= pwdata[6:0];
          if (wr_en && idx == g && bank == 2'h1)
            tx_cfg_q[g] <= pwdata[6:0];
          // aligned stays set once any sync has been taken
          if (rx_seen[g])
            rx_aligned_q[g] <= 1'b1; // R9
          if (tx_seen[g])
            tx_aligned_q[g] <= 1'b1;
          if (tx_edge)
            tx_out_q <= tx_cfg_q[g][`SPFA_CFG_FORCE_HIGH] | tx_bit_in[g]; // R11 R13
        end
      end

      spfa_dir rx_dir (
        .clk(clk),
        .rst_n(rst_n),
        .line_clock(rx_line_clock[g]),
        .line_sync(rx_frame_sync[g]),
        .line_data(rx_line_data[g]),
        .clk_inv(rx_cfg_q[g][`SPFA_CFG_CLK_INV]),
        .sync_inv(rx_cfg_q[g][`SPFA_CFG_SYNC_INV]),
        .early_mode(rx_cfg_q[g][`SPFA_CFG_EARLY_LSB+1:`SPFA_CFG_EARLY_LSB]),
        .frame_mode(rx_cfg_q[g][`SPFA_CFG_MODE_LSB+1:`SPFA_CFG_MODE_LSB]),
        .data_edge(rx_bit_valid[g]),
        .sync_seen(rx_seen[g]),
        .bit_count_q(rx_cnt[g]),
        .byte_edge(rx_byte_start[g]),
        .frame_edge(rx_frame_start[g]),
        .data_q(rx_bit_out[g])
      ); // R1 R3 R7

      spfa_dir tx_dir (
        .clk(clk),
        .rst_n(rst_n),
        .line_clock(tx_line_clock[g]),
        .line_sync(tx_frame_sync[g]),
        .line_data(1'b0),
        .clk_inv(tx_cfg_q[g][`SPFA_CFG_CLK_INV]),
        .sync_inv(tx_cfg_q[g][`SPFA_CFG_SYNC_INV]),
        .early_mode(tx_cfg_q[g][`SPFA_CFG_EARLY_LSB+1:`SPFA_CFG_EARLY_LSB]),
        .frame_mode(tx_cfg_q[g][`SPFA_CFG_MODE_LSB+1:`SPFA_CFG_MODE_LSB]),
        .data_edge(tx_edge),
        .sync_seen(tx_seen[g]),
        .bit_count_q(tx_cnt[g]),
        .byte_edge(tx_byte_start[g]),
        .frame_edge(tx_frame_start[g]),
        .data_q()
      ); // R15 R16

      assign tx_bit_take[g] = tx_edge;
      // force high acts at once, not only on the next line edge
      assign tx_line_data[g] = tx_out_q | tx_cfg_q[g][`SPFA_CFG_FORCE_HIGH]; // R13
    end
  endgenerate
endmodule

`default_nettype wire

// ### tb/spfa_line_model.sv
// spfa_line_model.sv: line framer model with one line clock, data and syncs
// assumes the bench fans these lines out to every port
`default_nettype none
module spfa_line_model (
  output logic line_clock,
  output logic line_data,
  output wire logic rx_sync,
  output wire logic tx_sync,
  input wire logic run,
  input wire logic sync_inv,
  input wire logic data_bit
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rx_act = 1'b0;
  logic tx_act = 1'b0;
  // ----
  // line side
  // ----
  initial begin
    line_clock = 1'b0;
    line_data = 1'b0;
  end
  always begin
    #80;
    if (run) line_clock = ~line_clock;
  end
  // data moves on falling edges so it is steady at the rising sample
  always @(negedge line_clock) line_data = data_bit;
  assign rx_sync = rx_act ^ sync_inv;
  assign tx_sync = tx_act ^ sync_inv;
  task automatic pulse(input logic tx);
    @(posedge line_clock);
    if (tx) tx_act = 1'b1;
    else rx_act = 1'b1;
    @(posedge line_clock);
    {rx_act, tx_act} = 2'b00;
  endtask
endmodule
`default_nettype wire

// ### tb/spfa_top_sva.sv
// spfa_top_sva.sv: timing checks on the serial front end outputs
// assumes bind into spfa_top, one clock domain on clk
`default_nettype none
module spfa_chk #(
  parameter NPORT = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NPORT-1:0] rx_bit_out,
  input wire logic [NPORT-1:0] rx_bit_valid,
  input wire logic [NPORT-1:0] rx_byte_start,
  input wire logic [NPORT-1:0] rx_frame_start,
  input wire logic [NPORT-1:0] tx_bit_take,
  input wire logic [NPORT-1:0] tx_byte_start,
  input wire logic [NPORT-1:0] tx_frame_start
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rx_byte_edge: assert property ((rx_byte_start & ~rx_bit_valid) == '0)
    else $error("rx byte start off a bit edge");
  chk_tx_byte_edge: assert property ((tx_byte_start & ~tx_bit_take) == '0)
    else $error("tx byte start off a bit edge");
  chk_rx_frame_byte: assert property ((rx_frame_start & ~rx_byte_start) == '0)
    else $error("rx frame start off a byte edge");
  chk_tx_frame_byte: assert property ((tx_frame_start & ~tx_byte_start) == '0)
    else $error("tx frame start off a byte edge");
  // 10 MHz line clocks leave at least four clk between edges
  chk_rx_edge_space: assert property (rx_bit_valid[0] |=> !rx_bit_valid[0] [*3])
    else $error("rx bit edges too close");
  chk_tx_edge_space: assert property (tx_bit_take[0] |=> !tx_bit_take[0] [*3])
    else $error("tx bit edges too close");
  chk_rx_bit_hold: assert property (!rx_bit_valid[0] |-> $stable(rx_bit_out[0]))
    else $error("rx bit moved without a sample");
  chk_rx_frame_gap: assert property (rx_frame_start[0] |=> !rx_frame_start[0] [*4])
    else $error("rx frame starts too close");
endmodule
bind spfa_top spfa_chk #(.NPORT(NPORT)) u_chk (.clk(clk), .rst_n(rst_n),
  .rx_bit_out(rx_bit_out), .rx_bit_valid(rx_bit_valid), .rx_byte_start(rx_byte_start),
  .rx_frame_start(rx_frame_start), .tx_bit_take(tx_bit_take),
  .tx_byte_start(tx_byte_start), .tx_frame_start(tx_frame_start));
`default_nettype wire

// ### tb/test_spfa_top.sv
// test_spfa_top.sv: apb driven checks of the serial port front end
// assumes spfa_top, the line model and the checker compiled first
`default_nettype none
module test_spfa_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, run = 1'b1, sinv = 1'b0, dbit = 1'b0;
  logic lclk, ldat, rsync, tsync;
  logic [15:0] tx_bit_in = 16'h0, txd, rbo, rbv, rbs, rfs, tbt, tbs, tfs;
  int err_total = 0, checked = 0, n, nb;
  int lens[4] = '{193, 256, 512, 1024};
  always #10 clk = ~clk;
  spfa_line_model line (.line_clock(lclk), .line_data(ldat), .rx_sync(rsync),
    .tx_sync(tsync), .run(run), .sync_inv(sinv), .data_bit(dbit));
  spfa_top #(.NPORT(16)) dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_line_clock({16{lclk}}), .rx_line_data({16{ldat}}),
    .rx_frame_sync({16{rsync}}), .tx_line_clock({16{lclk}}), .tx_frame_sync({16{tsync}}),
    .tx_bit_in(tx_bit_in), .tx_line_data(txd), .rx_bit_out(rbo), .rx_bit_valid(rbv),
    .rx_byte_start(rbs), .rx_frame_start(rfs), .tx_bit_take(tbt), .tx_byte_start(tbs),
    .tx_frame_start(tfs));
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // sel 0 rx bit, 1 tx bit, 2 rx frame start, 3 tx frame start
  task automatic wait_ev(input int sel, input int k);
    int t;
    logic [3:0] ev;
    t = 0;
    while (k > 0 && t < 20000) begin
      @(posedge clk);
      t++;
      ev = {tfs[0], rfs[0], tbt[0], rbv[0]};
      if (ev[sel] === 1'b1) k--;
    end
    if (k > 0) chk("event wait", 32'h0, 32'h1);
  endtask
  // counts sel events and rx byte starts up to and including the stop event
  task automatic count_to(input int sel, input int stop, output int cnt, output int bytes);
    logic [3:0] ev;
    cnt = 0;
    bytes = 0;
    do begin
      @(posedge clk);
      ev = {tfs[0], rfs[0], tbt[0], rbv[0]};
      if (ev[sel] === 1'b1) cnt++;
      if (rbs[0] === 1'b1) bytes++;
    end while (ev[stop] !== 1'b1 && cnt < 2000);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    #1500000;
    err_total++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("rx config reset", 32'h0, rd);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("test registers done");
    dbit = 1'b1;
    wait_ev(0, 3);
    chk("rx bit high", 32'h1, {31'h0, rbo[0]});
    dbit = 1'b0;
    wait_ev(0, 3);
    chk("rx bit low", 32'h0, {31'h0, rbo[0]});
    $display("test rx data done");
    line.pulse(1'b0);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 12'h000, m << 4);
      wait_ev(2, 1);
      count_to(0, 2, n, nb);
      chk("frame length", lens[m], n);
      chk("byte starts", (lens[m] - 1) / 8 + 1, nb);
    end
    // counter has just rolled, so no natural roll falls inside the early checks
    apb(1'b1, 12'h000, 32'h38);
    line.pulse(1'b0);
    count_to(0, 2, n, nb);
    chk("one early lead", 32'h2, n);
    apb(1'b1, 12'h000, 32'h3c);
    line.pulse(1'b0);
    count_to(0, 2, n, nb);
    chk("two early lead", 32'h3, n);
    apb(1'b0, 12'h080, 32'h0);
    chk("rx aligned", 32'h1, {31'h0, rd[10]});
    $display("test rx frames done");
    apb(1'b1, 12'h040, 32'h40);
    wait_ev(1, 2);
    chk("tx forced", 32'h1, {31'h0, txd[0]});
    apb(1'b1, 12'h040, 32'h0);
    wait_ev(1, 3);
    chk("tx zero", 32'h0, {31'h0, txd[0]});
    tx_bit_in <= 16'hffff;
    wait_ev(1, 3);
    chk("tx one", 32'h1, {31'h0, txd[0]});
    $display("test tx data done");
    // stop the line so the polarity swap cannot look like a tx sync edge
    run = 1'b0;
    apb(1'b1, 12'h040, 32'h2);
    sinv = 1'b1;
    run = 1'b1;
    wait_ev(1, 4);
    apb(1'b0, 12'h0c0, 32'h0);
    chk("tx not aligned", 32'h0, {31'h0, rd[10]});
    line.pulse(1'b1);
    wait_ev(1, 4);
    apb(1'b0, 12'h0c0, 32'h0);
    chk("tx aligned", 32'h1, {31'h0, rd[10]});
    wait_ev(3, 1);
    count_to(1, 3, n, nb);
    chk("tx frame length", lens[0], n);
    $display("test tx sync done");
    give_verdict;
  end
endmodule
`default_nettype wire
